// [ssc_pkg.sv]
// package: register map, field layout, reset values and timing of the serial channel block
package ssc_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int NCH = 2;
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;
    localparam int BITS = 8;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [AW-1:0] OFF_MASK = 8'h00;
    localparam logic [AW-1:0] OFF_STOP = 8'h04;
    localparam logic [AW-1:0] OFF_START = 8'h08;
    localparam logic [AW-1:0] OFF_IRQ = 8'h0c;
    localparam logic [AW-1:0] OFF_CFG0 = 8'h10;
    localparam logic [AW-1:0] OFF_CFG1 = 8'h14;
    localparam logic [AW-1:0] OFF_MODE0 = 8'h18;
    localparam logic [AW-1:0] OFF_MODE1 = 8'h1c;
    localparam logic [AW-1:0] OFF_STAT0 = 8'h20;
    localparam logic [AW-1:0] OFF_STAT1 = 8'h24;
    localparam logic [AW-1:0] OFF_TXD = 8'h28;
    localparam logic [AW-1:0] OFF_RXD = 8'h2c;
    localparam logic [AW-1:0] OFF_RATE = 8'h30;
    // ****************************************
    // field positions
    // ****************************************
    localparam int IRQ_BIT = 3;
    localparam int MASK_BIT = 3;
    localparam int TXE_BIT = 15;
    localparam int RXE_BIT = 14;
    localparam int SRC_BIT = 0;
    localparam int SIS_BIT = 6;
    localparam int STS_BIT = 8;
    localparam int TSF_BIT = 6;
    localparam int BFF_BIT = 5;
    // ****************************************
    // reset values and write masks
    // ****************************************
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [15:0] CFG_RST = 16'h0007;
    localparam logic [15:0] CFG_FIX = 16'h0004;
    localparam logic [15:0] MODE_RST = 16'h0020;
    localparam logic [15:0] MODE0_WMASK = 16'hc007;
    localparam logic [15:0] MODE1_WMASK = 16'hc147;
    localparam logic [11:0] RATE_RST = 12'h3e8;
    localparam logic [11:0] RATE_MIN = 12'h0c8;
    localparam logic [11:0] RATE_MAX = 12'h7d0;
    localparam int CLK_KHZ = 125000;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_SHIFT = 2'b11,
        ST_DONE = 2'b10
    } ssc_state_t;
endpackage

// [ssc_slave_model.sv]
// stand-in for the serial slave on the far side of the link
module ssc_slave_model (
    input wire logic ser_clk,
    input wire logic ser_dout,
    output logic ser_din,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte,
    output logic [15:0] rx_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // a frame cut by a stop leaves the count mid-byte; a long high clock restarts it
    // limitation: the gap assumes the bench runs the link at its top rate
    localparam realtime IDLE_GAP = 600.0;
    int idx;
    logic armed;
    logic [7:0] sh;
    realtime t_rise;
    initial begin
        idx = 0;
        t_rise = 0.0;
        armed = 1'b0;
        sh = 8'h00;
        rx_byte = 8'h00;
        rx_count = 16'h0000;
        ser_din = 1'b0;
    end
    // new bit on each falling edge, msb first
    always @(negedge ser_clk) begin
        if ($realtime - t_rise > IDLE_GAP) begin
            idx = 0;
        end
        armed = 1'b1;
        ser_din = tx_byte[7-idx];
    end
    // only a rising edge after a falling one counts: the reset edge does not
    always @(posedge ser_clk) begin
        t_rise = $realtime;
        if (armed) begin
            sh = {sh[6:0], ser_dout};
            idx = idx + 1;
            if (idx == 8) begin
                idx = 0;
                rx_byte = sh;
                rx_count = rx_count + 16'h0001;
                // bit time is over: a late sample must not see valid data
                ser_din = ~ser_din;
            end
        end
    end
endmodule

// [ssc_top.sv]
// serial channel control: transmit fifo, bus slave, channel triggers and shifter
// Behaviour
// - per-channel source bit: 0 flags transfer end, 1 flags transmit buffer empty
// - writing 1 to a stop bit clears that channel's enable and halts it
// - writing 1 to a start bit sets that channel's enable, waiting for data
// - config bits 15 and 14 pick off, receive, transmit or full duplex
// - irq request register bit 3 reads 1 while a request is pending
// - irq mask register bit 3: 0 lets the request out, 1 blocks it
// - two channels, each trigger bit at its channel number
// - inversion and start select exist only in channel 1 mode register
// - transfer rate configurable 200 to 2000 kbps, default 1000 kbps
// - status bit 6 reads 1 while that channel's transfer is in progress
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
module ssc_fifo #(parameter int W = 8, parameter int D = 16) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [PW:0] wp_r, rp_r, wp_nxt, rp_nxt;
    logic push, pop;
    always_comb begin
        in_ready = (wp_r - rp_r) != (PW+1)'(D);
        out_valid = wp_r != rp_r;
        out_data = mem[rp_r[PW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_nxt = wp_r + {{PW{1'b0}}, push};
        rp_nxt = rp_r + {{PW{1'b0}}, pop};
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r[PW-1:0]] <= in_data;
        end
    end
endmodule

module ssc_top (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [ssc_pkg::AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ssc_pkg::DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ssc_pkg::AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ssc_pkg::DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic ser_clk,
    output logic ser_dout,
    input wire logic ser_din,
    output logic irq
);
    import ssc_pkg::*;

    // ****************************************
    // bus slave
    // ****************************************
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [AW-1:0] wa, wa_nxt;
    logic [DW-1:0] wd, wd_nxt, rdata_r, rdata_nxt, rd_c;
    logic [3:0] ws, ws_nxt;
    logic awready_r, wready_r, bvalid_r, bvalid_nxt, arready_r, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic wr_go, rd_go, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_dout;
    logic [15:0] lane_m;

    function automatic logic mapped(input logic [AW-1:0] a);
        return a inside {OFF_MASK, OFF_STOP, OFF_START, OFF_IRQ, OFF_CFG0, OFF_CFG1,
                         OFF_MODE0, OFF_MODE1, OFF_STAT0, OFF_STAT1, OFF_TXD, OFF_RXD,
                         OFF_RATE};
    endfunction

    always_comb begin
        // a full fifo holds the write off, stalling the master
        wr_go = aw_full_r && w_full_r && !bvalid_r && (wa != OFF_TXD || fifo_in_ready);
        rd_go = s_axi_arvalid && arready_r;
        aw_full_nxt = wr_go ? 1'b0 : (aw_full_r || (s_axi_awvalid && awready_r));
        w_full_nxt = wr_go ? 1'b0 : (w_full_r || (s_axi_wvalid && wready_r));
        wa_nxt = (s_axi_awvalid && awready_r) ? s_axi_awaddr : wa;
        wd_nxt = (s_axi_wvalid && wready_r) ? s_axi_wdata : wd;
        ws_nxt = (s_axi_wvalid && wready_r) ? s_axi_wstrb : ws;
        bvalid_nxt = wr_go || (bvalid_r && !s_axi_bready);
        bresp_nxt = wr_go ? (mapped(wa) ? RESP_OK : RESP_ERR) : bresp_r;
        rvalid_nxt = rd_go || (rvalid_r && !s_axi_rready);
        rresp_nxt = rd_go ? (mapped(s_axi_araddr) ? RESP_OK : RESP_ERR) : rresp_r;
        rdata_nxt = rd_go ? rd_c : rdata_r;
        lane_m = {{8{ws[1]}}, {8{ws[0]}}};
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            wa <= '0;
            wd <= '0;
            ws <= '0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OK;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OK;
            rdata_r <= '0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            wa <= wa_nxt;
            wd <= wd_nxt;
            ws <= ws_nxt;
            awready_r <= !aw_full_nxt;
            wready_r <= !w_full_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= !rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ssc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_txq (
        .clk(sys_clk),
        .rstn(rstn),
        .in_data(wd[7:0]),
        .in_valid(wr_go && wa == OFF_TXD && ws[0]),
        .in_ready(fifo_in_ready),
        .out_data(fifo_dout),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );

    // ****************************************
    // control registers
    // ****************************************
    logic [7:0] mask_r, mask_nxt, rx_r, rx_nxt;
    logic [NCH-1:0] en_r, en_nxt, tsf;
    logic [NCH-1:0][15:0] cfg_r, cfg_nxt, mode_r, mode_nxt;
    logic [11:0] rate_r, rate_nxt, rate_w;
    logic flag_r, flag_nxt, rxf_r, rxf_nxt, irq_r, ev;
    ssc_state_t st_r, st_nxt;
    logic chan_r, chan_nxt;
    logic [7:0] sh_r, sh_nxt;

    always_comb begin
        mask_nxt = (wr_go && wa == OFF_MASK && ws[0]) ? wd[7:0] : mask_r;
        for (int i = 0; i < NCH; i++) begin
            en_nxt[i] = en_r[i];
            if (wr_go && wa == OFF_START && ws[0] && wd[i]) en_nxt[i] = 1'b1;
            if (wr_go && wa == OFF_STOP && ws[0] && wd[i]) en_nxt[i] = 1'b0;
            cfg_nxt[i] = cfg_r[i];
            if (wr_go && wa == OFF_CFG0 + AW'(4 * i)) begin
                cfg_nxt[i] = (cfg_r[i] & ~lane_m) | (wd[15:0] & lane_m) | CFG_FIX;
            end
            mode_nxt[i] = mode_r[i];
            if (wr_go && wa == OFF_MODE0 + AW'(4 * i)) begin
                // channel 0 keeps inversion and start select fixed
                mode_nxt[i] = (mode_r[i] & ~(lane_m & (i == 0 ? MODE0_WMASK : MODE1_WMASK)))
                    | (wd[15:0] & lane_m & (i == 0 ? MODE0_WMASK : MODE1_WMASK));
            end
            tsf[i] = st_r != ST_IDLE && chan_r == 1'(i);
        end
        rate_w = (rate_r & ~lane_m[11:0]) | (wd[11:0] & lane_m[11:0]);
        rate_nxt = rate_r;
        if (wr_go && wa == OFF_RATE) begin
            // out-of-range rates clamp so the divider stays inside its span
            rate_nxt = rate_w < RATE_MIN ? RATE_MIN : (rate_w > RATE_MAX ? RATE_MAX : rate_w);
        end
        flag_nxt = (wr_go && wa == OFF_IRQ && ws[0]) ? wd[IRQ_BIT] : flag_r;
        if (ev) flag_nxt = 1'b1;
        rx_nxt = rx_r;
        rxf_nxt = rxf_r;
        if (rd_go && s_axi_araddr == OFF_RXD) rxf_nxt = 1'b0;
        if (st_r == ST_DONE && cfg_r[chan_r][RXE_BIT]) begin
            rx_nxt = sh_r;
            rxf_nxt = 1'b1;
        end
        rd_c = '0;
        case (s_axi_araddr)
            OFF_MASK: rd_c[7:0] = mask_r;
            OFF_IRQ: rd_c[IRQ_BIT] = flag_r;
            OFF_CFG0: rd_c[15:0] = cfg_r[0];
            OFF_CFG1: rd_c[15:0] = cfg_r[1];
            OFF_MODE0: rd_c[15:0] = mode_r[0];
            OFF_MODE1: rd_c[15:0] = mode_r[1];
            OFF_STAT0, OFF_STAT1: begin
                rd_c[TSF_BIT] = tsf[s_axi_araddr == OFF_STAT1];
                rd_c[BFF_BIT] = fifo_out_valid;
            end
            OFF_RXD: rd_c[7:0] = rx_r;
            OFF_RATE: rd_c[11:0] = rate_r;
            default: rd_c = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= MASK_RST;
            en_r <= '0;
            cfg_r <= {NCH{CFG_RST}};
            mode_r <= {NCH{MODE_RST}};
            rate_r <= RATE_RST;
            flag_r <= 1'b0;
            rx_r <= '0;
            rxf_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            mask_r <= mask_nxt;
            en_r <= en_nxt;
            cfg_r <= cfg_nxt;
            mode_r <= mode_nxt;
            rate_r <= rate_nxt;
            flag_r <= flag_nxt;
            rx_r <= rx_nxt;
            rxf_r <= rxf_nxt;
            irq_r <= flag_r && !mask_r[MASK_BIT];
        end
    end

    // ****************************************
    // shift engine
    // ****************************************
    logic [3:0] bit_r, bit_nxt;
    logic [8:0] cnt_r, cnt_nxt, half_c;
    logic sclk_r, sclk_nxt, dout_r, dout_nxt, din_s1_r, din_s2_r, din_b, sel, go, txe;

    always_comb begin
        half_c = 9'(CLK_KHZ / (2 * int'(rate_r)));
        sel = !en_r[0];
        go = en_r[sel] && (cfg_r[sel][TXE_BIT] || cfg_r[sel][RXE_BIT]) && fifo_out_valid;
        txe = cfg_r[chan_r][TXE_BIT];
        din_b = din_s2_r ^ (chan_r && mode_r[1][SIS_BIT]);
        // source bit chooses which event raises the request
        ev = mode_r[chan_r][SRC_BIT] ? (st_r == ST_LOAD && !fifo_out_valid)
                                     : (st_r == ST_DONE);
        st_nxt = st_r;
        chan_nxt = chan_r;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        cnt_nxt = cnt_r;
        sclk_nxt = sclk_r;
        dout_nxt = dout_r;
        fifo_pop = 1'b0;
        case (st_r)
            ST_IDLE: begin
                sclk_nxt = 1'b1;
                if (go) begin
                    fifo_pop = 1'b1;
                    sh_nxt = fifo_dout;
                    chan_nxt = sel;
                    st_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                cnt_nxt = half_c - 9'd1;
                bit_nxt = '0;
                st_nxt = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (!en_r[chan_r]) begin
                    st_nxt = ST_IDLE;
                    sclk_nxt = 1'b1;
                end else if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 9'd1;
                end else begin
                    cnt_nxt = half_c - 9'd1;
                    sclk_nxt = !sclk_r;
                    if (sclk_r) begin
                        dout_nxt = txe ? sh_r[7] : 1'b1;
                    end else begin
                        sh_nxt = {sh_r[6:0], din_b};
                        bit_nxt = bit_r + 4'd1;
                        if (bit_r == 4'(BITS - 1)) st_nxt = ST_DONE;
                    end
                end
            end
            ST_DONE: st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= ST_IDLE;
            chan_r <= 1'b0;
            sh_r <= '0;
            bit_r <= '0;
            cnt_r <= '0;
            sclk_r <= 1'b1;
            dout_r <= 1'b1;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            chan_r <= chan_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            cnt_r <= cnt_nxt;
            sclk_r <= sclk_nxt;
            dout_r <= dout_nxt;
            din_s1_r <= ser_din;
            din_s2_r <= din_s1_r;
        end
    end

    always_comb begin
        s_axi_awready = awready_r;
        s_axi_wready = wready_r;
        s_axi_bvalid = bvalid_r;
        s_axi_bresp = bresp_r;
        s_axi_arready = arready_r;
        s_axi_rvalid = rvalid_r;
        s_axi_rresp = rresp_r;
        s_axi_rdata = rdata_r;
        ser_clk = sclk_r;
        ser_dout = dout_r;
        irq = irq_r;
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_stop0;
        wr_go && wa == OFF_STOP && ws[0] && wd[0];
    endsequence
    sequence s_start1;
        wr_go && wa == OFF_START && ws[0] && wd[1];
    endsequence
    sequence s_irq_rd;
        rd_go && s_axi_araddr == OFF_IRQ;
    endsequence

    a_src_end: assert property (st_r == ST_DONE && !mode_r[chan_r][SRC_BIT] |=> flag_r)
        else $error("transfer end did not raise request");
    // a pop in the stop cycle still passes through load before the abort
    a_stop_clears: assert property (s_stop0 |=> !en_r[0] ##2 (st_r != ST_SHIFT || chan_r))
        else $error("stop left channel running");
    a_start_sets: assert property (s_start1 |=> en_r[1])
        else $error("start did not enable channel");
    a_rx_only_idle: assert property (st_r == ST_SHIFT && !txe && $fell(sclk_r) |=> !ser_dout == 1'b0)
        else $error("receive only drove data out");
    a_flag_read: assert property (s_irq_rd |=> s_axi_rdata[IRQ_BIT] == $past(flag_r))
        else $error("request flag read wrong");
    a_mask_pass: assert property (flag_r && !mask_r[MASK_BIT] |=> irq)
        else $error("unmasked request not passed out");
    a_mask_block: assert property (mask_r[MASK_BIT] |=> !irq)
        else $error("mask did not block request");
    a_ch0_fixed: assert property (!mode_r[0][SIS_BIT] && !mode_r[0][STS_BIT])
        else $error("channel 0 fixed bits changed");
    a_rate_span: assert property (rate_r >= RATE_MIN && rate_r <= RATE_MAX)
        else $error("rate left its span");
    a_busy_flag: assert property (st_r == ST_SHIFT |-> tsf[chan_r] && !tsf[!chan_r])
        else $error("progress flag wrong");
endmodule

// [sync_serial_channel_control_tb_top.sv]
// self-checking bench for the serial channel control block
module sync_serial_channel_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ssc_pkg::*;
    logic sys_clk, rstn, irq, ser_clk, ser_dout, ser_din;
    logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DW-1:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] rx_byte;
    logic [15:0] rx_count, exp_cnt;
    int num_errors, num_checks, n_wait;

    ssc_top dut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ser_clk, .ser_dout,
        .ser_din, .irq);
    ssc_slave_model link (.ser_clk, .ser_dout, .ser_din, .tx_byte(8'h3c), .rx_byte,
        .rx_count);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bready and rready stay high, so the master never has to toggle them
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        n_wait = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n_wait++;
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (s_axi_bvalid !== 1'b1 && n_wait < 20000);
        chk(32'(s_axi_bvalid), 32'h1);
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int k;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
            if (s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
            end
        end while (s_axi_rvalid !== 1'b1 && k < 1000);
        rdv = s_axi_rdata;
        chk(32'(s_axi_rvalid), 32'h1);
        chk(32'(s_axi_rresp), 32'(er));
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, RESP_OK);
        chk(rdv, e);
    endtask

    task automatic poll(input logic [7:0] a, input int b, input logic v, input int max);
        int k;
        k = 0;
        do begin
            rd(a, RESP_OK);
            k++;
        end while (rdv[b] !== v && k < max);
        chk(32'(rdv[b]), 32'(v));
    endtask

    task automatic wait_irq(input logic v, input int max);
        int k;
        k = 0;
        while (irq !== v && k < max) begin
            @(posedge sys_clk);
            k++;
        end
        chk(32'(irq), 32'(v));
    endtask

    // mask and stop first, then configure; start and unmask only when asked
    task automatic set_mode(input int ch, input logic [15:0] cfg, input logic [15:0] md,
        input logic go);
        wr(OFF_MASK, 32'h0000_00ff, RESP_OK);
        wr(OFF_STOP, 32'(1 << ch), RESP_OK);
        wr(OFF_CFG0 + 8'(4 * ch), {16'h0000, cfg}, RESP_OK);
        wr(OFF_MODE0 + 8'(4 * ch), {16'h0000, md}, RESP_OK);
        if (go) begin
            wr(OFF_START, 32'(1 << ch), RESP_OK);
            wr(OFF_IRQ, 32'h0000_0000, RESP_OK);
            wr(OFF_MASK, 32'h0000_00f7, RESP_OK);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        $display("ERROR %0t watchdog expired", $time);
        print_verdict();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        rstn = 1'b0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        exp_cnt = 16'h0000;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        rc(OFF_MASK, {24'h0, MASK_RST});
        rc(OFF_CFG0, {16'h0, CFG_RST});
        rc(OFF_MODE1, {16'h0, MODE_RST});
        rc(OFF_RATE, {20'h0, RATE_RST});
        rc(OFF_IRQ, 32'h0);
        rc(OFF_STAT0, 32'h0);
        rc(OFF_START, 32'h0);
        rd(8'h3c, RESP_ERR);
        chk(rdv, 32'h0);
        wr(8'h3c, 32'h1, RESP_ERR);
        wr(OFF_RATE, 32'd100, RESP_OK);
        rc(OFF_RATE, {20'h0, RATE_MIN});
        wr(OFF_RATE, 32'd3000, RESP_OK);
        rc(OFF_RATE, {20'h0, RATE_MAX});
        wr(OFF_MODE0, 32'h0000_c147, RESP_OK);
        rc(OFF_MODE0, 32'h0000_c027);
        wr(OFF_MODE1, 32'h0000_c147, RESP_OK);
        rc(OFF_MODE1, 32'h0000_c167);
        // receive only, transmit only, full duplex; transfer end raises the flag
        for (int m = 1; m < 4; m++) begin
            set_mode(0, {m[1:0], 14'h0007}, 16'h0020, 1'b1);
            rc(OFF_CFG0, {16'h0, m[1:0], 14'h0007});
            wr(OFF_TXD, 32'h5a, RESP_OK);
            exp_cnt++;
            wait_irq(1'b1, 2000);
            chk(32'(rx_count), 32'(exp_cnt));
            chk(32'(rx_byte), m[1] ? 32'h5a : 32'hff);
            if (m[0]) rc(OFF_RXD, 32'h3c);
            rc(OFF_IRQ, 32'h8);
            wr(OFF_IRQ, 32'h0, RESP_OK);
            rc(OFF_IRQ, 32'h0);
        end
        // one byte in the shifter, sixteen queued: the eighteenth push must wait
        set_mode(0, 16'h8007, 16'h0020, 1'b1);
        for (int i = 0; i < 18; i++) begin
            wr(OFF_TXD, 32'(8'h10 + i), RESP_OK);
        end
        chk(32'(n_wait > 60), 32'h1);
        exp_cnt = exp_cnt + 16'd18;
        // sixteen queued bytes need about 8000 cycles to drain
        poll(OFF_STAT0, BFF_BIT, 1'b0, 5000);
        poll(OFF_STAT0, TSF_BIT, 1'b0, 400);
        chk(32'(rx_count), 32'(exp_cnt));
        chk(32'(rx_byte), 32'h21);
        // buffer empty fires long before the byte is out; masked until cleared
        set_mode(0, 16'h8007, 16'h0021, 1'b1);
        wr(OFF_MASK, 32'hff, RESP_OK);
        wr(OFF_IRQ, 32'h0, RESP_OK);
        wr(OFF_TXD, 32'h77, RESP_OK);
        poll(OFF_IRQ, IRQ_BIT, 1'b1, 20);
        rc(OFF_STAT0, 32'h40);
        chk(32'(irq), 32'h0);
        wr(OFF_MASK, 32'hf7, RESP_OK);
        wait_irq(1'b1, 4);
        wr(OFF_STOP, 32'h0, RESP_OK);
        rc(OFF_STAT0, 32'h40);
        wr(OFF_STOP, 32'h1, RESP_OK);
        rc(OFF_STAT0, 32'h0);
        chk(32'(ser_clk), 32'h1);
        // disabled mode leaves the byte queued; channel 1 later takes it
        set_mode(0, 16'h0007, 16'h0020, 1'b1);
        wr(OFF_TXD, 32'h66, RESP_OK);
        repeat (40) @(posedge sys_clk);
        rc(OFF_STAT0, 32'h20);
        // channel 1 in full duplex with its input inverted
        set_mode(1, 16'hc007, 16'h0040, 1'b0);
        wr(OFF_STOP, 32'h1, RESP_OK);
        wr(OFF_START, 32'h0, RESP_OK);
        repeat (40) @(posedge sys_clk);
        rc(OFF_STAT1, 32'h20);
        wr(OFF_START, 32'h2, RESP_OK);
        poll(OFF_STAT1, TSF_BIT, 1'b1, 10);
        rc(OFF_STAT0, 32'h0);
        poll(OFF_STAT1, TSF_BIT, 1'b0, 400);
        rc(OFF_RXD, 32'hc3);
        chk(32'(rx_byte), 32'h66);
        chk(32'(rx_count), 32'(exp_cnt + 16'd1));
        print_verdict();
    end
endmodule
